// file: src/spp_top.sv
/*
  serial parameter protocol interpreter: parses host messages, answers with ack,
  nak, eot or a data reply through a transmit fifo. assumes a uart on the same
  clock delivering one 7-bit character per i_rx_valid pulse, and a parameter
  store answering o_par_rd with i_par_ack one or more cycles later.
*/
`timescale 1ns/1ps
// ==========================================================
// transmit fifo with registered output
module spp_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 16
) (
  input  wire logic             i_mclk,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        ov;
    logic [WIDTH-1:0]            od;
  } spp_fifo_t;
  spp_fifo_t f, next_f;
  logic      push;
  logic      pop;
  // pointer and count update; output stage refills when empty or taken
  always_comb begin
    next_f = f;
    push = i_in_valid && o_in_ready;
    pop = (f.cnt != '0) && (!f.ov || i_out_ready);
    if (i_out_ready) next_f.ov = 1'b0;
    if (pop) begin
      next_f.od = f.mem[f.rp];
      next_f.ov = 1'b1;
      next_f.rp = f.rp + 1'b1;
    end
    if (push) begin
      next_f.mem[f.wp] = i_in_data;
      next_f.wp = f.wp + 1'b1;
    end
    next_f.cnt = f.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) f <= '0;
    else f <= next_f;
  end
  assign o_in_ready  = f.cnt < (AW+1)'(DEPTH);  // back-pressure to the interpreter
  assign o_out_valid = f.ov;
  assign o_out_data  = f.od;
endmodule
// ==========================================================
// message interpreter
module spp_top import spp_pkg::*; #(
  parameter int DEPTH = 16
) (
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic [6:0]  i_rx_char,
  input  wire logic        i_rx_valid,
  input  wire logic        i_rx_err,
  input  wire logic [7:0]  i_drive_addr,
  output logic [6:0]       o_tx_char,
  output logic             o_tx_valid,
  input  wire logic        i_tx_ready,
  output logic             o_par_rd,
  output logic             o_par_wr,
  output logic [15:0]      o_par_num,
  output logic             o_par_wsign,
  output logic [15:0]      o_par_wmag,
  input  wire logic        i_par_ack,
  input  wire logic        i_par_known,
  input  wire logic        i_par_sign,
  input  wire logic [15:0] i_par_mag,
  input  wire logic [15:0] i_par_limit
);
  spp_regs_t  s, next_s;
  logic       f_ready;
  logic       can_tx;
  logic       rx;
  logic       digit;
  logic [6:0] rc;
  logic [6:0] rep;
  // assertions below all sample on the main clock, quiet during reset
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // ==========================================================
  // reply character for the current position
  always_comb begin
    case (s.cnt)
      4'h0: rep = C_STX;
      4'h1, 4'h2, 4'h3, 4'h4: rep = {DIG_HI, s.par[4*(4 - s.cnt) +: 4]};
      R_SIGN: rep = s.sgn ? C_MINUS : C_PLUS;
      4'h6, 4'h7, 4'h8, 4'h9: rep = {DIG_HI, s.mag[4*(9 - s.cnt) +: 4]};
      R_ETX: rep = C_ETX;
      default: rep = spp_fix(s.bcc);
    endcase
  end
  // ==========================================================
  // parser and reply sequencer
  always_comb begin
    next_s = s;
    next_s.rd = 1'b0;
    next_s.wr = 1'b0;
    next_s.wv = 1'b0;
    rc = i_rx_char;
    rx = i_rx_valid;
    digit = (rc >= C_ZERO) && (rc <= C_NINE);
    can_tx = f_ready && !s.wv;  // one write every other cycle keeps ready honest
    if (rx && i_rx_err) next_s.bad = 1'b1;
    if (rx && rc == C_EOT) begin
      next_s.st = S_ADDR;
      next_s.cnt = '0;
      next_s.own = 1'b1;
      next_s.all = 1'b1;
      next_s.bad = i_rx_err;
    end else begin
      case (s.st)
        S_ADDR: if (rx) begin
          // each address digit arrives twice
          next_s.own = s.own && (rc == {DIG_HI, s.cnt[1] ? i_drive_addr[3:0]
                                                       : i_drive_addr[7:4]});
          next_s.all = s.all && (rc == C_ZERO);
          next_s.cnt = s.cnt + 4'h1;
          if (s.cnt == ADDR_LAST) next_s.st = S_HEAD;
        end
        S_HEAD: if (rx) begin
          next_s.cnt = '0;
          next_s.bcc = '0;
          if (!(s.own || s.all)) next_s.st = S_IDLE;
          else if (rc == C_STX) begin
            next_s.wr_mode = 1'b1;
            next_s.st = S_PARAM;
          end else if (digit) begin
            next_s.wr_mode = 1'b0;
            next_s.par = {12'h000, rc[3:0]};
            next_s.cnt = 4'h1;
            next_s.st = S_PARAM;
          end else begin
            next_s.one = C_NAK;
            next_s.st = S_ONE;
          end
        end
        S_PARAM: if (rx) begin
          if (digit && s.cnt < PAR_LEN) begin
            next_s.par = {s.par[11:0], rc[3:0]};
            next_s.bcc = s.bcc ^ rc;
            next_s.cnt = s.cnt + 4'h1;
            if (s.wr_mode && s.cnt == PAR_LEN - 4'h1) begin
              next_s.st = S_WDATA;
              next_s.sgn = 1'b0;
              next_s.mag = '0;
              next_s.nd = '0;
            end
          end else if (!s.wr_mode && s.cnt == PAR_LEN && rc == C_ENQ
                       && !s.bad && !i_rx_err) begin
            next_s.rd = 1'b1;
            next_s.st = S_RDQ;
          end else begin
            next_s.one = C_NAK;
            next_s.st = S_ONE;
          end
        end
        S_WDATA: if (rx) begin
          next_s.bcc = s.bcc ^ rc;
          if (rc == C_ETX) next_s.st = S_WCHK;
          else begin
            if (s.nd == DATA_MAX) next_s.bad = 1'b1;
            else next_s.nd = s.nd + 3'h1;
            if ((rc == C_PLUS || rc == C_MINUS) && s.nd == '0) next_s.sgn = rc == C_MINUS;
            else if (digit || rc == C_SPACE) begin
              next_s.mag = {s.mag[11:0], digit ? rc[3:0] : 4'h0};
              if (s.mag[15:12] != 4'h0) next_s.bad = 1'b1;
            end else next_s.bad = 1'b1;
          end
        end
        S_WCHK: if (rx) begin
          if (s.bad || i_rx_err || rc != spp_fix(s.bcc)) begin
            next_s.one = C_NAK;
            next_s.st = S_ONE;
          end else begin
            next_s.rd = 1'b1;
            next_s.st = S_WQRY;
          end
        end
        S_WQRY: if (i_par_ack) begin
          next_s.st = S_ONE;
          if (!i_par_known || s.mag > i_par_limit) next_s.one = C_NAK;
          else begin
            next_s.wr = 1'b1;
            next_s.one = C_ACK;
          end
        end
        S_RDQ: if (i_par_ack) begin
          if (!i_par_known) begin
            next_s.one = C_EOT;
            next_s.st = S_ONE;
          end else begin
            next_s.sgn = i_par_sign;
            next_s.mag = i_par_mag;
            next_s.cnt = '0;
            next_s.bcc = '0;
            next_s.st = S_REPLY;
          end
        end
        S_REPLY: if (can_tx) begin
          next_s.wv = 1'b1;
          next_s.wd = rep;
          if (s.cnt != '0 && s.cnt != R_BCC) next_s.bcc = s.bcc ^ rep;
          next_s.cnt = s.cnt + 4'h1;
          if (s.cnt == R_BCC) next_s.st = S_AFTER;
        end
        S_AFTER: if (rx) begin
          next_s.rd = 1'b1;
          next_s.st = S_RDQ;
          if (rc == C_ACK) next_s.par = spp_step(s.par, 1'b1);
          else if (rc == C_BS) next_s.par = spp_step(s.par, 1'b0);
          else if (rc != C_NAK) begin
            next_s.rd = 1'b0;
            next_s.st = S_IDLE;
          end
        end
        S_ONE: if (can_tx) begin
          next_s.wv = 1'b1;
          next_s.wd = s.one;
          next_s.st = S_IDLE;
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) s <= '0;
    else s <= next_s;
  end
  // ==========================================================
  // transmit buffer and store outputs
  spp_fifo #(.WIDTH(7), .DEPTH(DEPTH)) u_fifo (
    .i_mclk      (i_mclk),
    .i_reset     (i_reset),
    .i_in_valid  (s.wv),
    .i_in_data   (s.wd),
    .o_in_ready  (f_ready),
    .o_out_valid (o_tx_valid),
    .o_out_data  (o_tx_char),
    .i_out_ready (i_tx_ready)
  );
  assign o_par_rd    = s.rd;
  assign o_par_wr    = s.wr;
  assign o_par_num   = s.par;
  assign o_par_wsign = s.sgn;
  assign o_par_wmag  = s.mag;
  // ==========================================================
  // checks
  logic eot_in;
  assign eot_in = rx && rc == C_EOT;
  a_eot_resync: assert property (eot_in |=> s.st == S_ADDR && s.cnt == '0)
    else $error("eot did not restart address reception");
  // a full transmit fifo stretches the reply, so the end is given a window
  a_reply_start: assert property (
    s.st == S_RDQ && i_par_ack && i_par_known && !eot_in
    |=> s.st == S_REPLY && s.cnt == '0 ##[24:200] s.st == S_AFTER)
    else $error("data reply did not run its twelve characters");
  a_reply_step: assert property (
    s.st == S_REPLY && can_tx && !eot_in |=> s.wv && s.cnt == $past(s.cnt) + 4'h1)
    else $error("reply character not written in order");
  a_unknown_eot: assert property (
    s.st == S_RDQ && i_par_ack && !i_par_known && !eot_in
    |=> s.st == S_ONE && s.one == C_EOT)
    else $error("unknown parameter not answered with eot");
  a_sign_char: assert property (
    s.st == S_REPLY && s.cnt == R_SIGN && can_tx && !eot_in
    |=> s.wd == C_PLUS || s.wd == C_MINUS)
    else $error("reply data does not start with a sign");
  a_bcc_floor: assert property (
    s.st == S_REPLY && s.cnt == R_BCC && can_tx && !eot_in
    |=> s.wd >= BCC_MIN)
    else $error("check character in control range");
  a_limit_nak: assert property (
    s.st == S_WQRY && i_par_ack && s.mag > i_par_limit && !eot_in
    |=> !s.wr && s.one == C_NAK)
    else $error("out of range value not refused");
  a_write_ok: assert property (
    s.wr |-> $past(s.st) == S_WQRY && $past(i_par_known) && !$past(s.bad))
    else $error("write applied without a clean message");
  a_ack_next: assert property (
    s.st == S_AFTER && rx && rc == C_ACK
    |=> s.rd && s.par == spp_step($past(s.par), 1'b1))
    else $error("ack did not step to next parameter");
  a_bs_prev: assert property (
    s.st == S_AFTER && rx && rc == C_BS
    |=> s.rd && s.par == spp_step($past(s.par), 1'b0))
    else $error("bs did not step to previous parameter");
  a_nak_same: assert property (
    s.st == S_AFTER && rx && rc == C_NAK
    |=> s.rd && $stable(s.par))
    else $error("nak did not repeat the parameter");
  c_reply: cover property (s.st == S_REPLY ##[1:40] s.st == S_AFTER);
  c_write: cover property (s.wr);
  c_step: cover property (s.st == S_AFTER ##1 s.rd ##[1:40] s.st == S_REPLY);
  c_full: cover property (!f_ready);
endmodule

// file: src/spp_pkg.sv
/*
  constants, states, register struct and helpers for the serial parameter interpreter.
  assumes 7-bit ascii characters from a uart that checks parity and framing itself.
*/
package spp_pkg;
  // ==========================================================
  // control characters and ascii classes
  localparam logic [6:0] C_EOT   = 7'h04;
  localparam logic [6:0] C_ENQ   = 7'h05;
  localparam logic [6:0] C_STX   = 7'h02;
  localparam logic [6:0] C_ETX   = 7'h03;
  localparam logic [6:0] C_ACK   = 7'h06;
  localparam logic [6:0] C_BS    = 7'h08;
  localparam logic [6:0] C_NAK   = 7'h15;
  localparam logic [6:0] C_ZERO  = 7'h30;
  localparam logic [6:0] C_NINE  = 7'h39;
  localparam logic [6:0] C_SPACE = 7'h20;
  localparam logic [6:0] C_PLUS  = 7'h2b;
  localparam logic [6:0] C_MINUS = 7'h2d;
  localparam logic [2:0] DIG_HI  = 3'h3;   // upper bits of an ascii digit
  localparam logic [6:0] BCC_MIN = 7'h20;  // lowest legal check character
  // ==========================================================
  // field counts and reply positions
  localparam logic [3:0] ADDR_LAST = 4'h3;
  localparam logic [3:0] PAR_LEN   = 4'h4;
  localparam logic [2:0] DATA_MAX  = 3'h5;
  localparam logic [3:0] R_SIGN    = 4'h5;
  localparam logic [3:0] R_ETX     = 4'ha;
  localparam logic [3:0] R_BCC     = 4'hb;
  // ==========================================================
  // states and registered state
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000, S_ADDR = 4'b0001, S_HEAD = 4'b0010, S_PARAM = 4'b0011,
    S_WDATA = 4'b0100, S_WCHK = 4'b0101, S_WQRY = 4'b0110, S_RDQ   = 4'b0111,
    S_REPLY = 4'b1000, S_AFTER = 4'b1001, S_ONE = 4'b1010
  } spp_state_t;
  typedef struct packed {
    spp_state_t  st;
    logic [3:0]  cnt;
    logic        wr_mode;
    logic        own;
    logic        all;
    logic        bad;
    logic [15:0] par;
    logic        sgn;
    logic [15:0] mag;
    logic [2:0]  nd;
    logic [6:0]  bcc;
    logic [6:0]  one;
    logic        rd;
    logic        wr;
    logic        wv;
    logic [6:0]  wd;
  } spp_regs_t;
  // ==========================================================
  // check character floor
  function automatic logic [6:0] spp_fix(input logic [6:0] x);
    return (x < BCC_MIN) ? x + BCC_MIN : x;
  endfunction
  // four-digit bcd step up or down, wrapping
  function automatic logic [15:0] spp_step(input logic [15:0] v, input logic up);
    logic [15:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (c) begin
        if (up) begin
          if (r[4*i +: 4] == 4'h9) r[4*i +: 4] = 4'h0;
          else begin
            r[4*i +: 4] = r[4*i +: 4] + 4'h1;
            c = 1'b0;
          end
        end else begin
          if (r[4*i +: 4] == 4'h0) r[4*i +: 4] = 4'h9;
          else begin
            r[4*i +: 4] = r[4*i +: 4] - 4'h1;
            c = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction
endpackage

// file: test/spp_host.sv
/*
  host model for the serial parameter interpreter: builds read and write
  messages character by character and collects what the drive sends back.
  assumes the character uart sits on the design side of the boundary.
*/
`timescale 1ns/1ps
module spp_host import spp_pkg::*; (
  input  wire logic       i_mclk,
  input  wire logic [6:0] i_tx_char,
  input  wire logic       i_tx_valid,
  output logic [6:0]      o_rx_char,
  output logic            o_rx_valid,
  output logic            o_rx_err,
  output logic            o_tx_ready
);
  logic [6:0] rxq[$];
  logic       stall;
  int         cyc;
  initial begin
    o_rx_char  = 7'h7f;
    o_rx_valid = 1'b0;
    o_rx_err   = 1'b0;
    o_tx_ready = 1'b0;
    stall      = 1'b0;
    cyc        = 0;
  end
  // ==========================================================
  // reply collection: takes two characters in three, none while stalled
  always begin
    @(posedge i_mclk);
    if (i_tx_valid === 1'b1 && o_tx_ready) rxq.push_back(i_tx_char);
    #1;
    cyc++;
    o_tx_ready = !stall && (cyc % 3 != 0);
  end
  // ==========================================================
  // one character per pulse; line shows the inverse once released
  task automatic send_char(input logic [6:0] c, input logic e);
    @(posedge i_mclk);
    #1;
    o_rx_char  = c;
    o_rx_err   = e;
    o_rx_valid = 1'b1;
    @(posedge i_mclk);
    #1;
    o_rx_valid = 1'b0;
    o_rx_char  = ~c;
    o_rx_err   = 1'b0;
  endtask
  function automatic logic [6:0] dig(input logic [3:0] d);
    return {DIG_HI, d};
  endfunction
  // reset code then doubled address digits
  task automatic send_addr(input logic [7:0] a);
    send_char(C_EOT, 1'b0);
    send_char(dig(a[7:4]), 1'b0);
    send_char(dig(a[7:4]), 1'b0);
    send_char(dig(a[3:0]), 1'b0);
    send_char(dig(a[3:0]), 1'b0);
  endtask
  task automatic send_read(input logic [7:0] a, input logic [15:0] n);
    send_addr(a);
    for (int i = 3; i >= 0; i--) send_char(dig(n[4*i +: 4]), 1'b0);
    send_char(C_ENQ, 1'b0);
  endtask
  // write message with check character, optionally spoiled
  task automatic send_write(input logic [7:0] a, input logic [15:0] n, input string d,
                            input logic bad, input int err_at);
    logic [6:0] x;
    logic [6:0] c;
    x = 7'h00;
    send_addr(a);
    send_char(C_STX, 1'b0);
    for (int i = 3; i >= 0; i--) begin
      c = dig(n[4*i +: 4]);
      x = x ^ c;
      send_char(c, 1'b0);
    end
    for (int i = 0; i < d.len(); i++) begin
      c = 7'(d.getc(i));
      x = x ^ c;
      send_char(c, i == err_at);
    end
    x = x ^ C_ETX;
    send_char(C_ETX, 1'b0);
    x = (x < 7'h20) ? x + 7'h20 : x;
    send_char(bad ? x ^ 7'h01 : x, 1'b0);
  endtask
endmodule

// file: test/tb_serial_parameter_protocol.sv
/*
  self-checking bench for spp_top: host model on the serial side, a small
  parameter store model here. assumes the store answers within a few cycles.
*/
`timescale 1ns/1ps
module tb_serial_parameter_protocol import spp_pkg::*; ;
  logic        i_mclk, i_reset, i_rx_valid, i_rx_err, i_tx_ready, o_tx_valid;
  logic [6:0]  i_rx_char, o_tx_char;
  logic [7:0]  i_drive_addr;
  logic        o_par_rd, o_par_wr, o_par_wsign, i_par_ack, i_par_known, i_par_sign;
  logic [15:0] o_par_num, o_par_wmag, i_par_mag, i_par_limit, seed, n;
  logic        smg_s[logic [15:0]];
  logic [15:0] smg_m[logic [15:0]];
  int          checks, err_total, wr_cnt;
  spp_top #(.DEPTH(16)) dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_rx_char(i_rx_char),
    .i_rx_valid(i_rx_valid), .i_rx_err(i_rx_err), .i_drive_addr(i_drive_addr),
    .o_tx_char(o_tx_char), .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready),
    .o_par_rd(o_par_rd), .o_par_wr(o_par_wr), .o_par_num(o_par_num),
    .o_par_wsign(o_par_wsign), .o_par_wmag(o_par_wmag), .i_par_ack(i_par_ack),
    .i_par_known(i_par_known), .i_par_sign(i_par_sign), .i_par_mag(i_par_mag),
    .i_par_limit(i_par_limit));
  spp_host host (.i_mclk(i_mclk), .i_tx_char(o_tx_char), .i_tx_valid(o_tx_valid),
    .o_rx_char(i_rx_char), .o_rx_valid(i_rx_valid), .o_rx_err(i_rx_err),
    .o_tx_ready(i_tx_ready));
  always #25 i_mclk = ~i_mclk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] cur_m(input logic [15:0] k);
    return smg_m.exists(k) ? smg_m[k] : {8'h00, k[7:0]};
  endfunction
  function automatic logic cur_s(input logic [15:0] k);
    return smg_s.exists(k) ? smg_s[k] : k[0];
  endfunction
  // ==========================================================
  // parameter store: menu 01 exists, limit 0500, answer after 1..4 cycles
  always @(posedge i_mclk) if (o_par_wr === 1'b1) begin
    smg_m[o_par_num] = o_par_wmag;
    smg_s[o_par_num] = o_par_wsign;
    wr_cnt++;
  end
  initial forever begin
    @(posedge i_mclk);
    if (o_par_rd === 1'b1) begin
      seed = lfsr(seed);
      repeat (1 + seed[1:0]) @(posedge i_mclk);
      #1;
      i_par_ack   = 1'b1;
      i_par_known = (o_par_num[15:8] == 8'h01);
      i_par_sign  = cur_s(o_par_num);
      i_par_mag   = cur_m(o_par_num);
      @(posedge i_mclk);
      #1;
      i_par_ack = 1'b0;
      i_par_mag = ~i_par_mag;
    end
  end
  // ==========================================================
  // comparisons and expectations
  task automatic cmp7(input logic [6:0] got, input logic [6:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: char %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic get_char(output logic [6:0] c);
    int t;
    t = 0;
    while (host.rxq.size() == 0 && t < 2000) begin
      @(posedge i_mclk);
      t++;
    end
    c = (host.rxq.size() == 0) ? 'x : host.rxq.pop_front();
  endtask
  task automatic expect_char(input logic [6:0] e);
    logic [6:0] g;
    get_char(g);
    cmp7(g, e);
  endtask
  task automatic expect_reply(input logic [15:0] k, input logic s, input logic [15:0] m);
    logic [6:0] e[12];
    logic [6:0] x;
    e[0] = C_STX;
    e[5] = s ? C_MINUS : C_PLUS;
    e[10] = C_ETX;
    x = 7'h00;
    for (int i = 0; i < 4; i++) begin
      e[1+i] = {DIG_HI, k[15-4*i -: 4]};
      e[6+i] = {DIG_HI, m[15-4*i -: 4]};
    end
    for (int i = 1; i < 11; i++) x = x ^ e[i];
    e[11] = (x < 7'h20) ? x + 7'h20 : x;
    for (int i = 0; i < 12; i++) expect_char(e[i]);
  endtask
  // write, answer code, write count, then read back for menu 01
  task automatic do_write(input logic [15:0] k, input string d, input logic bad,
                          input int err_at, input logic ok, input logic s,
                          input logic [15:0] m);
    logic        os;
    logic [15:0] om;
    int          w0;
    os = cur_s(k);
    om = cur_m(k);
    w0 = wr_cnt;
    host.send_write(8'h14, k, d, bad, err_at);
    expect_char(ok ? C_ACK : C_NAK);
    cmp16(16'(wr_cnt - w0), {15'h0000, ok});
    if (k[15:8] == 8'h01) begin
      host.send_read(8'h14, k);
      expect_reply(k, ok ? s : os, ok ? m : om);
    end
  endtask
  task report_and_stop;
    $display("checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // watchdog, well beyond the expected run of under two thousand cycles
  initial begin
    repeat (40000) @(posedge i_mclk);
    err_total++;
    report_and_stop;
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] m;
    i_mclk = 1'b0;
    i_reset = 1'b1;
    i_drive_addr = 8'h14;
    i_par_ack = 1'b0;
    i_par_known = 1'b0;
    i_par_sign = 1'b0;
    i_par_mag = 16'h0000;
    i_par_limit = 16'h0500;
    seed = 16'hb5a1;
    checks = 0;
    err_total = 0;
    wr_cnt = 0;
    repeat (5) @(posedge i_mclk);
    #1;
    i_reset = 1'b0;
    n = 16'h0117;
    host.send_read(8'h14, n);
    expect_reply(n, cur_s(n), cur_m(n));
    for (int i = 0; i < 3; i++) begin
      host.send_char(i == 0 ? C_NAK : (i == 1 ? C_ACK : C_BS), 1'b0);
      n = (i == 1) ? n + 16'h0001 : ((i == 2) ? n - 16'h0001 : n);
      expect_reply(n, cur_s(n), cur_m(n));
    end
    host.send_read(8'h14, 16'h0723);
    expect_char(C_EOT);
    host.send_read(8'h00, 16'h0105);
    expect_reply(16'h0105, 1'b1, 16'h0005);
    host.send_read(8'h15, 16'h0105);
    repeat (60) @(posedge i_mclk);
    cmp16(16'(host.rxq.size()), 16'h0000);
    host.send_addr(8'h14);
    host.send_char(C_ZERO, 1'b0);
    host.send_read(8'h14, 16'h0106);
    expect_reply(16'h0106, 1'b0, 16'h0006);
    host.send_addr(8'h14);
    host.send_char(C_ENQ, 1'b0);
    expect_char(C_NAK);
    do_write(16'h0117, "- 476", 1'b0, -1, 1'b1, 1'b1, 16'h0476);
    do_write(16'h0118, "+0600", 1'b0, -1, 1'b0, 1'b0, 16'h0600);
    do_write(16'h0118, "123456", 1'b0, -1, 1'b0, 1'b0, 16'h0000);
    do_write(16'h0118, "+12", 1'b1, -1, 1'b0, 1'b0, 16'h0012);
    do_write(16'h0118, "+12", 1'b0, 1, 1'b0, 1'b0, 16'h0012);
    do_write(16'h0723, "+1", 1'b0, -1, 1'b0, 1'b0, 16'h0001);
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      m = {4'h0, 4'(seed[3:0] % 10), 4'(seed[7:4] % 10), 4'(seed[11:8] % 10)};
      do_write(16'h0120 + 16'(k), $sformatf("%s%0d%0d%0d", seed[12] ? "-" : "+",
               m[11:8], m[7:4], m[3:0]), 1'b0, -1, m <= 16'h0500, seed[12], m);
    end
    host.stall = 1'b1;
    host.send_read(8'h14, 16'h0130);
    repeat (40) @(posedge i_mclk);
    host.send_char(C_ACK, 1'b0);
    repeat (60) @(posedge i_mclk);
    cmp16(16'(host.rxq.size()), 16'h0000);
    host.stall = 1'b0;
    expect_reply(16'h0130, 1'b0, 16'h0030);
    expect_reply(16'h0131, 1'b1, 16'h0031);
    report_and_stop;
  end
endmodule
